// ### pls_pkg.sv
// constants, register map and state types of the probe link status indicator
// assumes a single 40 MHz system clock and a classic wishbone register bus
// Notes on behaviour
// (RULE1) laser indicator dark while laser off
// (RULE2) laser on and starting: laser indicator blinks
// (RULE3) shutdown protection suspended during start-up, mode change
// (RULE4) running in mode: indicator steady, protection armed
// (RULE5) link indicator steady while frames arrive
// (RULE6) link failure: laser off, link indicator blinks
// (RULE7) master drives statistics enable and snapshot lines
// (RULE8) every unit drives its master/slave line
// (RULE9) master status indicator blinks
// (RULE10) slave indicator follows statistics enable
// (RULE11) two triggers, each input or output
// (RULE12) shared differential trigger pair for all units
// (RULE13) blink rate from programmable clock divider
package pls_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  localparam logic [7:0] BLINK_DIV_OFS = 8'h10;
  localparam logic [7:0] TRIG_OFS = 8'h14;
  localparam logic [7:0] FRAME_TMO_OFS = 8'h18;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTRL_LASER_REQ_BIT = 0;
  localparam int CTRL_MASTER_BIT = 1;
  localparam int CTRL_STATS_EN_BIT = 2;
  localparam int CTRL_SNAPSHOT_BIT = 3;
  localparam int CTRL_FAIL_CLR_BIT = 4;

  // trigger register fields: channel 0 bnc, channel 1 shared pair
  localparam int TRIG_DIR0_BIT = 0;
  localparam int TRIG_DIR1_BIT = 1;
  localparam int TRIG_OUT0_BIT = 2;
  localparam int TRIG_OUT1_BIT = 3;
  localparam int TRIG_IN0_BIT = 4;
  localparam int TRIG_IN1_BIT = 5;

  // interrupt events
  localparam int IRQ_LINK_FAIL_BIT = 0;
  localparam int IRQ_LINK_UP_BIT = 1;
  localparam int IRQ_TRIG0_BIT = 2;
  localparam int IRQ_TRIG1_BIT = 3;
  localparam int IRQ_W = 4;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [23:0] BLINK_DIV_RST = 24'h4c4b40; // 5e6 cycles: 8 Hz toggle, 4 Hz blink
  localparam logic [23:0] FRAME_TMO_RST = 24'h009c40; // 1 ms at 40 MHz
  localparam int CLK_HZ = 40000000;

  typedef enum logic [1:0] {
    PLS_OFF,
    PLS_START,
    PLS_RUN,
    PLS_FAIL
  } pls_state_t;

endpackage : pls_pkg

// ### pls_divider.sv
// programmable divider giving a one-cycle enable pulse
// assumes div_i comes from a software register; a count above a new divisor wraps at once
`timescale 1ns/100ps
module pls_divider #(
  parameter int W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] div_i,
  output logic tick_o
);
  logic [W-1:0] cnt_reg;

  // count down, pulse on wrap; zero acts as one, a smaller new divisor never waits out the old period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else if (cnt_reg == '0 || cnt_reg >= div_i) begin
      cnt_reg <= (div_i == '0) ? '0 : div_i - 1'b1; // [RULE13]
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
      tick_o <= 1'b0;
    end
  end

  a_tick_single: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
    tick_o && div_i > 1 && $stable(div_i) |=> !tick_o) else $error("tick longer than one cycle");
endmodule : pls_divider

// ### pls_trig_chan.sv
// one trigger channel, usable as input or output
// assumes trig_i is already synchronous to clk_i
`timescale 1ns/100ps
module pls_trig_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic out_mode_i,
  input wire logic out_val_i,
  input wire logic trig_i,
  output logic trig_o,
  output logic trig_oe_n_o,
  output logic level_o,
  output logic edge_o
);
  logic prev_reg;

  // drive when in output mode; enable low means driving
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_o <= 1'b0;
      trig_oe_n_o <= 1'b1;
    end else begin
      trig_o <= out_val_i; // [RULE11]
      trig_oe_n_o <= ~out_mode_i; // [RULE11]
    end
  end

  // sample the pin level and flag rising edges in input mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
      level_o <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      prev_reg <= trig_i;
      level_o <= trig_i;
      edge_o <= trig_i & ~prev_reg & ~out_mode_i; // [RULE11]
    end
  end

  a_trig_drive: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
    out_mode_i |=> !trig_oe_n_o) else $error("output channel not driving");
endmodule : pls_trig_chan

// ### pls_top.sv
// probe link status indicator: laser, data link, multi-unit and trigger logic
// assumes a wishbone classic master, frame strobes and probe phase inputs synchronous to clk_i
`timescale 1ns/100ps
module pls_top #(
  parameter int DIV_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // probe side
  input wire logic frame_ok_i,
  input wire logic probe_starting_i,
  input wire logic link_fail_i,
  output logic laser_en_o,
  output logic shutdown_arm_o,
  // front panel
  output logic led_laser_o,
  output logic led_link_o,
  // multi-unit link
  input wire logic stats_en_i,
  input wire logic snapshot_i,
  output logic stats_en_o,
  output logic snapshot_o,
  output logic stats_oe_n_o,
  output logic is_master_o,
  output logic led_unit_o,
  // triggers: 0 bnc, 1 shared differential pair (one logic level here)
  input wire logic [1:0] trig_i,
  output logic [1:0] trig_o,
  output logic [1:0] trig_oe_n_o,
  output logic irq_o
);

  // ****************************************
  // registers and internal signals
  // ****************************************
  logic laser_req_reg;
  logic master_reg;
  logic stats_req_reg;
  logic snap_req_reg;
  logic [DIV_W-1:0] blink_div_reg;
  logic [23:0] frame_tmo_reg;
  logic [1:0] trig_dir_reg;
  logic [1:0] trig_val_reg;
  logic [pls_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [pls_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [pls_pkg::IRQ_W-1:0] irq_evt;
  logic irq_pend;
  logic [23:0] silence_reg;
  logic receiving;
  logic receiving_reg;
  logic blink_reg;
  logic blink_tick;
  logic [1:0] trig_level;
  logic [1:0] trig_edge;
  logic fail_clr;
  logic wr_en;
  logic rd_en;
  pls_pkg::pls_state_t state_reg;
  pls_pkg::pls_state_t state_next;

  // writes land at the edge where the master samples ack; read data is prepared one edge earlier
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign fail_clr = wr_en && wb_adr_i == pls_pkg::CTRL_OFS && wb_dat_i[pls_pkg::CTRL_FAIL_CLR_BIT];

  // ****************************************
  // blink generator
  // ****************************************
  pls_divider #(
    .W(DIV_W)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_i(blink_div_reg),
    .tick_o(blink_tick)
  );

  // shared phase keeps all blinking leds in step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_reg <= 1'b0;
    end else if (blink_tick) begin
      blink_reg <= ~blink_reg; // [RULE13]
    end
  end

  // ****************************************
  // frame activity watch
  // ****************************************
  // silence counter: frames must keep arriving within the timeout
  // it parks at or above the timeout, so a cold start or a lowered timeout reads as no data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      silence_reg <= '1;
    end else if (frame_ok_i) begin
      silence_reg <= '0;
    end else if (silence_reg < frame_tmo_reg) begin
      silence_reg <= silence_reg + 24'h000001;
    end
  end
  assign receiving = silence_reg < frame_tmo_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receiving_reg <= 1'b0;
    end else begin
      receiving_reg <= receiving;
    end
  end

  // ****************************************
  // laser state machine
  // ****************************************
  // fail is sticky until software clears it, so the laser cannot restart by itself
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pls_pkg::PLS_OFF: begin
        if (laser_req_reg) state_next = pls_pkg::PLS_START;
      end
      pls_pkg::PLS_START: begin
        if (!laser_req_reg) state_next = pls_pkg::PLS_OFF;
        else if (link_fail_i) state_next = pls_pkg::PLS_FAIL; // [RULE6]
        else if (!probe_starting_i && receiving) state_next = pls_pkg::PLS_RUN;
      end
      pls_pkg::PLS_RUN: begin
        if (!laser_req_reg) state_next = pls_pkg::PLS_OFF;
        else if (link_fail_i) state_next = pls_pkg::PLS_FAIL; // [RULE6]
        else if (probe_starting_i) state_next = pls_pkg::PLS_START; // mode change
      end
      pls_pkg::PLS_FAIL: begin
        if (fail_clr) state_next = pls_pkg::PLS_OFF;
      end
      default: state_next = pls_pkg::PLS_OFF;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= pls_pkg::PLS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // laser drive, protection arming and panel leds, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      laser_en_o <= 1'b0;
      shutdown_arm_o <= 1'b0;
      led_laser_o <= 1'b0;
      led_link_o <= 1'b0;
    end else begin
      laser_en_o <= state_next == pls_pkg::PLS_START || state_next == pls_pkg::PLS_RUN; // [RULE6]
      shutdown_arm_o <= state_next == pls_pkg::PLS_RUN; // [RULE3] [RULE4]
      case (state_next)
        pls_pkg::PLS_START: led_laser_o <= blink_reg; // [RULE2]
        pls_pkg::PLS_RUN: led_laser_o <= 1'b1; // [RULE4]
        default: led_laser_o <= 1'b0; // [RULE1]
      endcase
      if (state_next == pls_pkg::PLS_FAIL) led_link_o <= blink_reg; // [RULE6]
      else led_link_o <= receiving; // [RULE5]
    end
  end

  // ****************************************
  // multi-unit coordination
  // ****************************************
  // only the master drives enable and snapshot; slaves listen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stats_en_o <= 1'b0;
      snapshot_o <= 1'b0;
      stats_oe_n_o <= 1'b1;
      is_master_o <= 1'b0;
      led_unit_o <= 1'b0;
    end else begin
      stats_en_o <= master_reg & stats_req_reg; // [RULE7]
      snapshot_o <= master_reg & snap_req_reg; // [RULE7]
      stats_oe_n_o <= ~master_reg; // [RULE7]
      is_master_o <= master_reg; // [RULE8]
      led_unit_o <= master_reg ? blink_reg : stats_en_i; // [RULE9] [RULE10]
    end
  end

  // ****************************************
  // trigger channels
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_trig
      // channel 1 is the pair common to all joined units
      pls_trig_chan u_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .out_mode_i(trig_dir_reg[gi]),
        .out_val_i(trig_val_reg[gi]),
        .trig_i(trig_i[gi]),
        .trig_o(trig_o[gi]),
        .trig_oe_n_o(trig_oe_n_o[gi]),
        .level_o(trig_level[gi]),
        .edge_o(trig_edge[gi])
      ); // [RULE11] [RULE12]
    end
  endgenerate

  // ****************************************
  // interrupts
  // ****************************************
  assign irq_evt = {trig_edge[1], trig_edge[0], receiving & ~receiving_reg,
    state_reg != pls_pkg::PLS_FAIL && state_next == pls_pkg::PLS_FAIL};

  // set wins over the write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
    end else if (wr_en && wb_adr_i == pls_pkg::IRQ_STAT_OFS) begin
      irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[pls_pkg::IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_evt;
    end
  end

  // pending level kept apart so the line can be checked one cycle later
  assign irq_pend = |(irq_stat_reg & irq_mask_reg);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_pend;
    end
  end

  // ****************************************
  // wishbone register file
  // ****************************************
  // writes; only byte lane 0 matters except for wide counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      laser_req_reg <= 1'b0;
      master_reg <= 1'b0;
      stats_req_reg <= 1'b0;
      snap_req_reg <= 1'b0;
      irq_mask_reg <= '0;
      blink_div_reg <= DIV_W'(pls_pkg::BLINK_DIV_RST);
      frame_tmo_reg <= pls_pkg::FRAME_TMO_RST;
      trig_dir_reg <= 2'h0;
      trig_val_reg <= 2'h0;
    end else begin
      snap_req_reg <= 1'b0; // snapshot request is a single-cycle pulse
      if (state_next == pls_pkg::PLS_FAIL) laser_req_reg <= 1'b0; // [RULE6]
      if (wr_en) begin
        case (wb_adr_i)
          pls_pkg::CTRL_OFS: begin
            if (state_next != pls_pkg::PLS_FAIL) laser_req_reg <= wb_dat_i[pls_pkg::CTRL_LASER_REQ_BIT];
            master_reg <= wb_dat_i[pls_pkg::CTRL_MASTER_BIT];
            stats_req_reg <= wb_dat_i[pls_pkg::CTRL_STATS_EN_BIT];
            snap_req_reg <= wb_dat_i[pls_pkg::CTRL_SNAPSHOT_BIT];
          end
          pls_pkg::IRQ_MASK_OFS: irq_mask_reg <= wb_dat_i[pls_pkg::IRQ_W-1:0];
          pls_pkg::BLINK_DIV_OFS: blink_div_reg <= wb_dat_i[DIV_W-1:0];
          pls_pkg::FRAME_TMO_OFS: frame_tmo_reg <= wb_dat_i[23:0];
          pls_pkg::TRIG_OFS: begin
            trig_dir_reg <= wb_dat_i[pls_pkg::TRIG_DIR1_BIT:pls_pkg::TRIG_DIR0_BIT];
            trig_val_reg <= wb_dat_i[pls_pkg::TRIG_OUT1_BIT:pls_pkg::TRIG_OUT0_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // ack one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (rd_en) begin
        case (wb_adr_i)
          pls_pkg::CTRL_OFS: wb_dat_o <= {28'h0000000, 1'b0, stats_req_reg, master_reg, laser_req_reg};
          pls_pkg::STAT_OFS: wb_dat_o <= {24'h000000, stats_en_i, snapshot_i, receiving, shutdown_arm_o,
            laser_en_o, 1'b0, state_reg};
          pls_pkg::IRQ_STAT_OFS: wb_dat_o <= {28'h0000000, irq_stat_reg};
          pls_pkg::IRQ_MASK_OFS: wb_dat_o <= {28'h0000000, irq_mask_reg};
          pls_pkg::BLINK_DIV_OFS: wb_dat_o <= 32'(blink_div_reg);
          pls_pkg::FRAME_TMO_OFS: wb_dat_o <= {8'h00, frame_tmo_reg};
          pls_pkg::TRIG_OFS: wb_dat_o <= {26'h0000000, trig_level, trig_val_reg, trig_dir_reg};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_laser_off_dark: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    !laser_en_o |-> !led_laser_o) else $error("laser led lit with laser off");
  a_start_no_arm: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    state_reg == pls_pkg::PLS_START |-> !shutdown_arm_o && laser_en_o) else $error("armed in start-up");
  a_start_blinks: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    state_reg == pls_pkg::PLS_START |-> led_laser_o == $past(blink_reg)) else $error("laser led not blinking");
  a_run_steady: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    state_reg == pls_pkg::PLS_RUN |-> led_laser_o && shutdown_arm_o) else $error("run not steady");
  a_link_led: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    state_next != pls_pkg::PLS_FAIL |=> led_link_o == $past(receiving)) else $error("link led wrong");
  a_fail_laser_off: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    link_fail_i && laser_en_o |=> !laser_en_o) else $error("laser stays on after failure");
  a_slave_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    !master_reg |=> stats_oe_n_o && !stats_en_o) else $error("slave drives stats lines");
  a_role_line: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    ##1 is_master_o == $past(master_reg)) else $error("role line wrong");
  a_unit_led: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    !master_reg |=> led_unit_o == $past(stats_en_i)) else $error("slave led wrong");
  a_master_blink: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
    master_reg |=> led_unit_o == $past(blink_reg)) else $error("master led not blinking");
  a_fail_link_blink: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    state_reg == pls_pkg::PLS_FAIL |-> led_link_o == $past(blink_reg)) else $error("link led steady in failure");
  a_fail_laser_dark: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1] [RULE6]
    state_reg == pls_pkg::PLS_FAIL |-> !laser_en_o && !led_laser_o) else $error("laser on in failure");
  a_snap_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    snapshot_o |=> !snapshot_o) else $error("snapshot longer than one cycle");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == $past(irq_pend)) else $error("interrupt line does not follow pending bits");

  c_run: cover property (@(posedge clk_i) state_reg == pls_pkg::PLS_START ##1 state_reg == pls_pkg::PLS_RUN);
  c_fail: cover property (@(posedge clk_i) state_reg == pls_pkg::PLS_FAIL);
  c_mode_change: cover property (@(posedge clk_i) state_reg == pls_pkg::PLS_RUN ##1 state_reg == pls_pkg::PLS_START);
  c_irq: cover property (@(posedge clk_i) irq_o);
  c_snapshot: cover property (@(posedge clk_i) snapshot_o);

endmodule : pls_top

// ### pls_probe_model.sv
// partner model: remote probe (frames, start-up phase, link fault) and peer units on the shared link
// assumes its control inputs change right after a rising edge of clk_i
`timescale 1ns/100ps
module pls_probe_model (
  input wire logic clk_i,
  input wire logic frames_on_i,
  input wire logic starting_i,
  input wire logic fail_i,
  input wire logic peer_stats_i,
  input wire logic [1:0] peer_trig_i,
  input wire logic dut_stats_i,
  input wire logic dut_snap_i,
  input wire logic dut_stats_oe_n_i,
  input wire logic [1:0] dut_trig_i,
  input wire logic [1:0] dut_trig_oe_n_i,
  output logic frame_ok_o,
  output logic probe_starting_o,
  output logic link_fail_o,
  output logic stats_en_o,
  output logic snapshot_o,
  output logic [1:0] trig_o
);
  logic [1:0] gap_reg = 2'h0;

  initial begin
    frame_ok_o = 1'b0;
    probe_starting_o = 1'b0;
    link_fail_o = 1'b0;
  end

  // one good frame every fourth cycle while powered, well inside the frame timeout
  always @(posedge clk_i) begin
    gap_reg <= gap_reg + 2'h1;
    frame_ok_o <= frames_on_i && (gap_reg == 2'h3);
    probe_starting_o <= starting_i;
    link_fail_o <= fail_i; // one-cycle fault pulse
  end

  // shared lines: the unit whose enable is low drives, otherwise a peer does
  assign stats_en_o = dut_stats_oe_n_i ? peer_stats_i : dut_stats_i;
  assign snapshot_o = dut_stats_oe_n_i ? 1'b0 : dut_snap_i; // a peer master never snapshots while the unit is a slave
  assign trig_o[0] = dut_trig_oe_n_i[0] ? peer_trig_i[0] : dut_trig_i[0];
  assign trig_o[1] = dut_trig_oe_n_i[1] ? peer_trig_i[1] : dut_trig_i[1];
endmodule : pls_probe_model

// ### tb_top.sv
// testbench: wishbone tasks drive the status block against the probe and peer model
// assumes pls_pkg, pls_top and pls_probe_model are compiled first
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, q;
  logic frames_on = 1'b0, starting = 1'b0, fail_req = 1'b0, peer_stats = 1'b0;
  logic [1:0] peer_trig = 2'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, frame_ok, probe_st, link_fail, laser_en_o, shutdown_arm_o, led_laser_o, led_link_o;
  logic stats_in, snap_in, stats_en_o, snapshot_o, stats_oe_n_o, is_master_o, led_unit_o, irq_o;
  logic [1:0] trig_in, trig_o, trig_oe_n_o;
  int error_cnt = 0, num_checks = 0, t, h, s;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  pls_top #(.DIV_W(24)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .frame_ok_i(frame_ok), .probe_starting_i(probe_st), .link_fail_i(link_fail), .laser_en_o(laser_en_o),
    .shutdown_arm_o(shutdown_arm_o), .led_laser_o(led_laser_o), .led_link_o(led_link_o),
    .stats_en_i(stats_in), .snapshot_i(snap_in), .stats_en_o(stats_en_o), .snapshot_o(snapshot_o),
    .stats_oe_n_o(stats_oe_n_o), .is_master_o(is_master_o), .led_unit_o(led_unit_o), .trig_i(trig_in),
    .trig_o(trig_o), .trig_oe_n_o(trig_oe_n_o), .irq_o(irq_o));

  pls_probe_model i_probe (.clk_i(clk_i), .frames_on_i(frames_on), .starting_i(starting), .fail_i(fail_req),
    .peer_stats_i(peer_stats), .peer_trig_i(peer_trig), .dut_stats_i(stats_en_o), .dut_snap_i(snapshot_o),
    .dut_stats_oe_n_i(stats_oe_n_o), .dut_trig_i(trig_o), .dut_trig_oe_n_i(trig_oe_n_o),
    .frame_ok_o(frame_ok), .probe_starting_o(probe_st), .link_fail_o(link_fail), .stats_en_o(stats_in),
    .snapshot_o(snap_in), .trig_o(trig_in));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one classic cycle; the request stands until ack is sampled high, which must take two edges
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    chk(n, 2); // ack one cycle after the request is taken
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q & m, exp);
  endtask : rdchk

  function automatic logic pick(input int idx);
    return (idx == 0) ? led_laser_o : (idx == 1) ? led_link_o : led_unit_o;
  endfunction : pick

  // counts level changes and lit cycles of one indicator over n cycles
  task automatic watch(input int idx, input int n);
    logic p;
    t = 0;
    h = 0;
    p = pick(idx);
    repeat (n) begin
      @(posedge clk_i);
      if ($isunknown(pick(idx))) h += 1000; // an unknown level must spoil the lit count
      if (pick(idx) !== p) t++;
      if (pick(idx) === 1'b1) h++;
      p = pick(idx);
    end
  endtask : watch

  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // watchdog: the sequence needs about 820 cycles
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(laser_en_o, 0);
    chk({stats_oe_n_o, trig_oe_n_o}, 3'h7);
    rdchk(pls_pkg::CTRL_OFS, 32'h1f, 0);
    rdchk(pls_pkg::BLINK_DIV_OFS, 32'hffffff, 32'h4c4b40);
    rdchk(pls_pkg::FRAME_TMO_OFS, 32'hffffff, 32'h009c40);
    rdchk(8'h1c, 32'hffffffff, 0); // unmapped reads zero
    watch(0, 32); chk(h, 0);
    watch(1, 32); chk(h, 0);
    // short blink and frame timeout keep the run brief
    xfer(1'b1, pls_pkg::BLINK_DIV_OFS, 32'h4);
    xfer(1'b1, pls_pkg::FRAME_TMO_OFS, 32'd20);
    rdchk(pls_pkg::BLINK_DIV_OFS, 32'hffffff, 32'h4);
    // start-up: laser on, blinking, protection suspended
    starting <= 1'b1;
    xfer(1'b1, pls_pkg::CTRL_OFS, 32'h1);
    repeat (3) @(posedge clk_i);
    chk({laser_en_o, shutdown_arm_o}, 2'b10);
    rdchk(pls_pkg::STAT_OFS, 32'h3, 32'h1);
    watch(0, 64); chk(t >= 6, 1);
    // frames arrive, probe in requested mode
    frames_on <= 1'b1; starting <= 1'b0;
    repeat (30) @(posedge clk_i);
    chk(shutdown_arm_o, 1);
    rdchk(pls_pkg::STAT_OFS, 32'h3, 32'h2);
    watch(0, 64); chk(h, 64);
    watch(1, 64); chk(h, 64);
    rdchk(pls_pkg::IRQ_STAT_OFS, 32'h2, 32'h2);
    // mode change suspends, its end restores protection
    starting <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(shutdown_arm_o, 0);
    watch(0, 64); chk(t >= 6, 1);
    starting <= 1'b0;
    repeat (30) @(posedge clk_i);
    chk(shutdown_arm_o, 1);
    // link fault: laser off, link indicator blinks, interrupt raised
    xfer(1'b1, pls_pkg::IRQ_MASK_OFS, 32'h1);
    fail_req <= 1'b1; frames_on <= 1'b0;
    @(posedge clk_i);
    fail_req <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(laser_en_o, 0);
    rdchk(pls_pkg::STAT_OFS, 32'h3, 32'h3);
    watch(1, 64); chk(t >= 6, 1);
    chk(irq_o, 1);
    xfer(1'b1, pls_pkg::CTRL_OFS, 32'h1); // refused while failed
    repeat (3) @(posedge clk_i);
    chk(laser_en_o, 0);
    rdchk(pls_pkg::IRQ_STAT_OFS, 32'h1, 32'h1);
    xfer(1'b1, pls_pkg::IRQ_MASK_OFS, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 0);
    xfer(1'b1, pls_pkg::IRQ_MASK_OFS, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1);
    xfer(1'b1, pls_pkg::IRQ_STAT_OFS, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 0);
    // clear the failure: laser stays off without a new request
    xfer(1'b1, pls_pkg::CTRL_OFS, 32'h10);
    repeat (30) @(posedge clk_i);
    rdchk(pls_pkg::STAT_OFS, 32'h3, 32'h0);
    watch(0, 32); chk(h, 0);
    watch(1, 32); chk(h, 0);
    // master: drives enable and snapshot, blinking unit indicator
    xfer(1'b1, pls_pkg::CTRL_OFS, 32'h6);
    repeat (3) @(posedge clk_i);
    chk({is_master_o, stats_oe_n_o, stats_en_o}, 3'b101);
    rdchk(pls_pkg::STAT_OFS, 32'h80, 32'h80);
    watch(2, 64); chk(t >= 6, 1);
    xfer(1'b1, pls_pkg::CTRL_OFS, 32'he);
    s = 0;
    repeat (8) begin
      @(posedge clk_i);
      if (snapshot_o === 1'b1) s++;
    end
    chk(s > 0, 1);
    chk(snapshot_o, 0);
    // slave: indicator follows the shared enable line
    xfer(1'b1, pls_pkg::CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({is_master_o, stats_oe_n_o}, 2'b01);
    watch(2, 32); chk(h, 0);
    peer_stats <= 1'b1;
    repeat (3) @(posedge clk_i);
    watch(2, 32); chk(h, 32);
    rdchk(pls_pkg::STAT_OFS, 32'h80, 32'h80);
    // triggers as outputs, each channel on its own
    xfer(1'b1, pls_pkg::TRIG_OFS, 32'h7);
    repeat (3) @(posedge clk_i);
    chk({trig_oe_n_o, trig_o}, 4'b0001);
    xfer(1'b1, pls_pkg::TRIG_OFS, 32'hb);
    repeat (3) @(posedge clk_i);
    chk({trig_oe_n_o, trig_o}, 4'b0010);
    // triggers as inputs: levels read back, rising edges flagged
    xfer(1'b1, pls_pkg::TRIG_OFS, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(trig_oe_n_o, 2'b11);
    xfer(1'b1, pls_pkg::IRQ_STAT_OFS, 32'hf);
    xfer(1'b1, pls_pkg::IRQ_MASK_OFS, 32'hc);
    peer_trig <= 2'b11;
    repeat (4) @(posedge clk_i);
    rdchk(pls_pkg::TRIG_OFS, 32'h30, 32'h30);
    rdchk(pls_pkg::IRQ_STAT_OFS, 32'hc, 32'hc);
    chk(irq_o, 1);
    tally_and_finish();
  end
endmodule : tb_top
